// >>> common/eeprom_port_pkg.sv
/*
 * constants, encodings and timing for the serial eeprom command port.
 * assumes a 100 MHz system clock; all link pins arrive asynchronously.
 */
`default_nettype none
package eeprom_port_pkg;

    // array geometry
    localparam int ADDR_BITS = 6;
    localparam int WORD_BITS = 16;
    localparam int WORDS = 64;

    // opcodes, sent most significant bit first
    localparam logic [1:0] OPC_SPECIAL = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;

    // special commands in the two leading address bits
    localparam logic [1:0] SPC_DISABLE = 2'h0;
    localparam logic [1:0] SPC_WRITE_ALL = 2'h1;
    localparam logic [1:0] SPC_ERASE_ALL = 2'h2;
    localparam logic [1:0] SPC_ENABLE = 2'h3;

    // field counts inside a frame (last index of each field, bit count for read)
    localparam logic [4:0] OPC_LAST = 5'h01;
    localparam logic [4:0] ADDR_LAST = 5'h05;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [4:0] READ_BITS = 5'h10;

    // erased word value
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // timing, figures in their own units
    localparam int CLOCK_MHZ = 100;
    localparam int CLOCK_NS = 10;
    localparam int WRITE_TIME_MS = 2;
    localparam int ERASE_TIME_MS = 1;
    localparam int ALL_TIME_MS = 15;
    localparam int CS_LOW_NS = 100;
    // longest times round down, least time rounds up
    localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int ALL_CYCLES = ALL_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int CS_LOW_CYCLES = (CS_LOW_NS + CLOCK_NS - 1) / CLOCK_NS;

    // width of the programming timer and of the select-low counter
    localparam int TIMER_BITS = 21;
    localparam int LOW_BITS = 4;

    // frame sequencer, gray along the usual path
    typedef enum logic [2:0] {
        F_IDLE = 3'h0,
        F_OPC = 3'h1,
        F_ADDR = 3'h3,
        F_DATA = 3'h2,
        F_READ = 3'h6,
        F_DONE = 3'h7
    } frame_t;

    // programming jobs queued for the self-timed engine
    typedef enum logic [1:0] {
        JOB_ERASE = 2'h0,
        JOB_WRITE = 2'h1,
        JOB_ERASE_ALL = 2'h2,
        JOB_WRITE_ALL = 2'h3
    } job_t;

    localparam int JOB_BITS = 2 + ADDR_BITS + WORD_BITS;

endpackage
`default_nettype wire

// >>> hdl/job_fifo.sv
/*
 * small synchronous fifo with valid and ready on both sides.
 * assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module job_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];    // storage words
    logic [PW-1:0] wr_ptr;            // next slot to fill
    logic [PW-1:0] rd_ptr;            // next slot to drain
    logic [PW:0] count;               // words held
    logic do_push;
    logic do_pop;

    assign in_ready = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    // storage, no reset needed
    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

endmodule
`default_nettype wire

// >>> hdl/eeprom_command_port.sv
/*
 * command and protocol engine of a 64 x 16 serial eeprom: frame
 * decoder on a three-wire link, self-timed programming, status out.
 * assumes chip_select, serial_clock and serial_data_in are asynchronous
 * pins; serial_clock is far slower than clock (1 MHz or less).
 */
// Overview of operation
// - start on first rising edge, select and data high
// - nothing happens before a start bit
// - select high leaves standby
// - execute only after every required bit
// - after last bit ignore link until select low
// - start, two-bit opcode, six-bit address, msb first
// - opcode zero picks special command by address
// - read sends zero dummy then 16 bits
// - dummy follows last address edge, launched on rise
// - output released next rise or select low
// - read bit holds while select stays high
// - write erases then programs within 2 ms
// - erase sets word to ones, 1 ms
// - erase all sets array ones, 15 ms
// - write all programs without erase, 15 ms
// - programming refused until enable command
// - status shown on select rise after low time
// - otherwise data out stays released
// - sample and launch on rising serial clock
// - select low resets control, programming finishes
`timescale 1ns/1ps
`default_nettype none
module eeprom_command_port #(
    parameter int WRITE_CYCLES = eeprom_port_pkg::WRITE_CYCLES,
    parameter int ERASE_CYCLES = eeprom_port_pkg::ERASE_CYCLES,
    parameter int ALL_CYCLES = eeprom_port_pkg::ALL_CYCLES,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic chip_select,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_en
);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic cs_s1;                          // select, first stage
        logic cs_s2;                          // select, synchronised
        logic sck_s1;                         // link clock, first stage
        logic sck_s2;                         // link clock, synchronised
        logic sck_prev;                       // for edge detection
        logic di_s1;                          // data in, first stage
        logic di_s2;                          // data in, synchronised
        eeprom_port_pkg::frame_t frame;       // frame sequencer
        logic [4:0] cnt;                      // bits in current field
        logic [1:0] opc;                      // received opcode
        logic [5:0] addr;                     // received address
        logic [15:0] sh;                      // data in or read out
        logic enabled;                        // programming allowed
        logic dout;                           // data out level
        logic dout_en;                        // data out driven
        logic armed;                          // status may be shown
        logic status_on;                      // status being driven
        logic [eeprom_port_pkg::LOW_BITS-1:0] low_cnt; // select low time
        logic prog;                           // engine running
        eeprom_port_pkg::job_t job;           // running job
        logic [5:0] job_addr;                 // running job address
        logic [15:0] job_data;                // running job data
        logic [eeprom_port_pkg::TIMER_BITS-1:0] timer; // cycles left
    } state_t;

    state_t s;                    // registered state
    state_t next_s;               // next state
    logic [15:0] mem [eeprom_port_pkg::WORDS]; // the array
    logic rise;                   // rising link clock edge
    logic busy;                   // a job queued or running
    logic push;                   // enqueue a job
    logic push_req;               // frame asks for a job
    logic commit;                 // job time elapsed, apply it
    eeprom_port_pkg::job_t push_job; // job being asked for
    logic [5:0] addr_full;        // address with the bit now arriving
    logic [15:0] data_full;       // data with the bit now arriving
    logic fifo_in_ready;          // queue has room
    logic fifo_out_valid;         // queue holds a job
    logic [eeprom_port_pkg::JOB_BITS-1:0] fifo_out; // head job

    assign rise = s.sck_s2 && !s.sck_prev;
    assign addr_full = {s.addr[4:0], s.di_s2};
    assign data_full = {s.sh[14:0], s.di_s2};
    assign busy = s.prog || fifo_out_valid;
    assign push = push_req && s.enabled && fifo_in_ready;

    ////////////////////////////////////////////////////////////////////
    // job queue between the frame decoder and the programming engine

    // a full queue refuses the job, the frame then ends without effect
    job_fifo #(
        .WIDTH(eeprom_port_pkg::JOB_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_jobs (
        .clock(clock),
        .rstn(rstn),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        // a write frame holds its address, erase takes it live
        .in_data({push_job,
            (s.frame == eeprom_port_pkg::F_DATA) ? s.addr : addr_full,
            data_full}),
        .out_valid(fifo_out_valid),
        .out_ready(!s.prog),
        .out_data(fifo_out)
    );

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s = s;
        push_req = 1'b0;
        push_job = eeprom_port_pkg::JOB_ERASE;
        commit = 1'b0;
        // two-stage synchronisers on every pin
        next_s.cs_s1 = chip_select;
        next_s.cs_s2 = s.cs_s1;
        next_s.sck_s1 = serial_clock;
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_prev = s.sck_s2;
        next_s.di_s1 = serial_data_in;
        next_s.di_s2 = s.di_s1;

        if (!s.cs_s2) begin
            next_s.frame = eeprom_port_pkg::F_IDLE;
            next_s.cnt = '0;
            next_s.dout_en = 1'b0;
            next_s.status_on = 1'b0;
            if (s.low_cnt != eeprom_port_pkg::LOW_BITS'(
                    eeprom_port_pkg::CS_LOW_CYCLES)) begin
                next_s.low_cnt = s.low_cnt + 1'b1;
            end
            // job done and select low: no more status to offer
            if (!busy) begin
                next_s.armed = 1'b0;
            end
        end else begin
            next_s.low_cnt = '0;
            // status after long enough select low
            if (s.armed && s.low_cnt == eeprom_port_pkg::LOW_BITS'(
                    eeprom_port_pkg::CS_LOW_CYCLES)) begin
                next_s.status_on = 1'b1;
                next_s.dout_en = 1'b1;
                // valid level from the first driven cycle, no stale bit
                next_s.dout = !busy;
            end
            // low while busy, high when ready
            if (s.status_on) begin
                next_s.dout = !busy;
            end
            if (rise) begin
                unique case (s.frame)
                    eeprom_port_pkg::F_IDLE: begin
                        if (s.di_s2) begin
                            next_s.frame = eeprom_port_pkg::F_OPC;
                            next_s.cnt = '0;
                            next_s.status_on = 1'b0;
                            next_s.dout_en = 1'b0;
                        end
                    end
                    eeprom_port_pkg::F_OPC: begin
                        next_s.opc = {s.opc[0], s.di_s2};
                        next_s.cnt = s.cnt + 1'b1;
                        if (s.cnt == eeprom_port_pkg::OPC_LAST) begin
                            next_s.frame = eeprom_port_pkg::F_ADDR;
                            next_s.cnt = '0;
                        end
                    end
                    eeprom_port_pkg::F_ADDR: begin
                        next_s.addr = addr_full;
                        next_s.cnt = s.cnt + 1'b1;
                        // decode only on the last address bit
                        if (s.cnt == eeprom_port_pkg::ADDR_LAST) begin
                            next_s.cnt = '0;
                            next_s.frame = eeprom_port_pkg::F_DONE;
                            unique case (s.opc)
                                eeprom_port_pkg::OPC_READ: begin
                                    next_s.frame = eeprom_port_pkg::F_READ;
                                    next_s.dout = 1'b0;
                                    next_s.dout_en = 1'b1;
                                    next_s.sh = mem[addr_full];
                                end
                                eeprom_port_pkg::OPC_ERASE: begin
                                    push_req = 1'b1;
                                    push_job = eeprom_port_pkg::JOB_ERASE;
                                end
                                eeprom_port_pkg::OPC_WRITE: begin
                                    next_s.frame = eeprom_port_pkg::F_DATA;
                                end
                                eeprom_port_pkg::OPC_SPECIAL: begin
                                    unique case (addr_full[5:4])
                                        eeprom_port_pkg::SPC_ENABLE:
                                            next_s.enabled = 1'b1;
                                        eeprom_port_pkg::SPC_DISABLE:
                                            next_s.enabled = 1'b0;
                                        eeprom_port_pkg::SPC_ERASE_ALL: begin
                                            push_req = 1'b1;
                                            push_job =
                                                eeprom_port_pkg::JOB_ERASE_ALL;
                                        end
                                        eeprom_port_pkg::SPC_WRITE_ALL:
                                            next_s.frame =
                                                eeprom_port_pkg::F_DATA;
                                    endcase
                                end
                            endcase
                        end
                    end
                    eeprom_port_pkg::F_DATA: begin
                        next_s.sh = data_full;
                        next_s.cnt = s.cnt + 1'b1;
                        // the 25th clock completes the frame
                        if (s.cnt == eeprom_port_pkg::DATA_LAST) begin
                            next_s.frame = eeprom_port_pkg::F_DONE;
                            push_req = 1'b1;
                            push_job = (s.opc == eeprom_port_pkg::OPC_WRITE)
                                ? eeprom_port_pkg::JOB_WRITE
                                : eeprom_port_pkg::JOB_WRITE_ALL;
                        end
                    end
                    eeprom_port_pkg::F_READ: begin
                        if (s.cnt == eeprom_port_pkg::READ_BITS) begin
                            next_s.dout_en = 1'b0;
                            next_s.frame = eeprom_port_pkg::F_DONE;
                        end else begin
                            // bit changes only on a rise
                            next_s.dout = s.sh[15];
                            next_s.sh = {s.sh[14:0], 1'b0};
                            next_s.cnt = s.cnt + 1'b1;
                        end
                    end
                    eeprom_port_pkg::F_DONE: begin
                        next_s.frame = eeprom_port_pkg::F_DONE;
                    end
                    default: begin
                        next_s.frame = eeprom_port_pkg::F_IDLE;
                    end
                endcase
            end
        end

        // an accepted job makes status available on the next select
        if (push_req && s.enabled && fifo_in_ready) begin
            next_s.armed = 1'b1;
        end

        if (!s.prog) begin
            if (fifo_out_valid) begin
                next_s.prog = 1'b1;
                next_s.job = eeprom_port_pkg::job_t'(fifo_out[23:22]);
                next_s.job_addr = fifo_out[21:16];
                next_s.job_data = fifo_out[15:0];
                unique case (eeprom_port_pkg::job_t'(fifo_out[23:22]))
                    eeprom_port_pkg::JOB_ERASE:
                        next_s.timer = eeprom_port_pkg::TIMER_BITS'(
                            ERASE_CYCLES - 1);
                    eeprom_port_pkg::JOB_WRITE:
                        next_s.timer = eeprom_port_pkg::TIMER_BITS'(
                            WRITE_CYCLES - 1);
                    default:
                        next_s.timer = eeprom_port_pkg::TIMER_BITS'(
                            ALL_CYCLES - 1);
                endcase
            end
        end else if (s.timer == '0) begin
            next_s.prog = 1'b0;
            commit = 1'b1;
        end else begin
            next_s.timer = s.timer - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // array update at the end of the self-timed cycle
    always_ff @(posedge clock) begin
        if (commit) begin
            unique case (s.job)
                eeprom_port_pkg::JOB_ERASE:
                    mem[s.job_addr] <= eeprom_port_pkg::ERASED_WORD;
                // erase then program gives the data
                eeprom_port_pkg::JOB_WRITE:
                    mem[s.job_addr] <= s.job_data;
                eeprom_port_pkg::JOB_ERASE_ALL:
                    for (int i = 0; i < eeprom_port_pkg::WORDS; i++) begin
                        mem[i] <= eeprom_port_pkg::ERASED_WORD;
                    end
                // program only clears bits, no erase
                eeprom_port_pkg::JOB_WRITE_ALL:
                    for (int i = 0; i < eeprom_port_pkg::WORDS; i++) begin
                        mem[i] <= mem[i] & s.job_data;
                    end
            endcase
        end
    end

    assign serial_data_out = s.dout;
    // driven only for read or status
    assign serial_data_out_en = s.dout_en;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_start_detect: assert property (
        s.cs_s2 && rise && s.di_s2 && s.frame == eeprom_port_pkg::F_IDLE
        |=> s.frame == eeprom_port_pkg::F_OPC)
        else $error("start bit not taken");
    a_idle_quiet: assert property (
        s.frame == eeprom_port_pkg::F_IDLE && !(rise && s.di_s2)
        |=> s.frame == eeprom_port_pkg::F_IDLE && !push)
        else $error("activity before start bit");
    a_done_ignores: assert property (
        s.frame == eeprom_port_pkg::F_DONE && s.cs_s2
        |=> s.frame == eeprom_port_pkg::F_DONE)
        else $error("link not ignored after frame");
    a_dummy_zero: assert property (
        s.cs_s2 && rise && s.frame == eeprom_port_pkg::F_ADDR
        && s.cnt == eeprom_port_pkg::ADDR_LAST
        && s.opc == eeprom_port_pkg::OPC_READ
        |=> serial_data_out_en && !serial_data_out)
        else $error("read dummy bit missing");
    a_enable_guard: assert property (
        !s.enabled && !busy |=> !busy)
        else $error("job started while disabled");
    a_out_hiz: assert property (
        serial_data_out_en
        |-> s.frame == eeprom_port_pkg::F_READ || s.status_on)
        else $error("data out driven outside read or status");
    a_timer_runs: assert property (
        s.prog && s.timer != '0 |=> s.prog && s.timer == $past(s.timer) - 1)
        else $error("programming timer stalled");
    a_cs_release: assert property (
        !s.cs_s2 |=> s.frame == eeprom_port_pkg::F_IDLE && !serial_data_out_en)
        else $error("select low did not reset control");
    a_status_level: assert property (
        s.status_on && s.cs_s2 && $past(s.status_on)
        |=> serial_data_out == $past(!busy))
        else $error("status level wrong");

    c_read_done: cover property (
        s.frame == eeprom_port_pkg::F_READ ##1
        s.frame == eeprom_port_pkg::F_DONE);
    c_job_pushed: cover property (push);
    c_status_busy: cover property (s.status_on && busy);
    c_commit: cover property (commit);

endmodule
`default_nettype wire

// >>> verif/link_master.sv
/* link controller model: select, serial clock and data in.
   assumes the bench resolves data out onto line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module link_master (
    input wire logic clock,
    input wire logic line,
    output logic chip_select,
    output logic serial_clock,
    output logic serial_data_in
);
    // deselected, clock parked low between frames
    initial begin
        chip_select = 1'b0;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // msb first frame
    task automatic xfer(input int n, input logic [31:0] v,
            output logic [15:0] rd);
        rd = 16'h0000;
        @(negedge clock) chip_select <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in <= v[i];
            repeat (8) @(negedge clock);
            serial_clock <= 1'b1;
            repeat (8) @(negedge clock);
            serial_clock <= 1'b0;
            // bit stands until next rise, so take it here
            rd = {rd[14:0], line};
        end
        repeat (2) @(negedge clock);
        chip_select <= 1'b0;
        serial_data_in <= ~serial_data_in;
        repeat (12) @(negedge clock);
    endtask
    // status poll, data in left quiet
    task automatic poll(output logic busy, output logic ready);
        @(negedge clock) chip_select <= 1'b1;
        repeat (6) @(negedge clock);
        busy = (line === 1'b0);
        ready = 1'b0;
        for (int k = 0; k < 2000 && !ready; k++) begin
            @(negedge clock);
            ready = (line === 1'b1);
        end
        chip_select <= 1'b0;
        repeat (12) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// >>> verif/serial_eeprom_command_port_bench.sv
/* bench for the eeprom command port: a table of frames, then reset.
   assumes the link model drives pins at falling clock edges. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    err_total++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module serial_eeprom_command_port_bench;
    typedef struct packed {
        logic [4:0] n; // rises sent
        logic [31:0] v; // frame, low n bits
        logic c; // compare read word
        logic b; // busy expected at poll
        logic [15:0] e; // expected word
    } row_t;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic chip_select, serial_clock, serial_data_in;
    logic serial_data_out, serial_data_out_en;
    // pull-up when the port lets go
    wire logic line = serial_data_out_en ? serial_data_out : 1'b1;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    row_t rows [18] = '{
        '{5'h09, 32'h00000130, 1'b0, 1'b0, 16'h0000},
        '{5'h09, 32'h00000120, 1'b0, 1'b1, 16'h0000},
        '{5'h19, 32'h01850000, 1'b1, 1'b0, 16'hFFFF},
        '{5'h19, 32'h0145A55A, 1'b0, 1'b1, 16'h0000},
        '{5'h1B, 32'h01850000, 1'b1, 1'b0, 16'hA55A},
        '{5'h1A, 32'h030A0000, 1'b1, 1'b0, 16'h4AB5},
        '{5'h14, 32'h000A2891, 1'b0, 1'b0, 16'h0000},
        '{5'h19, 32'h01850000, 1'b1, 1'b0, 16'hA55A},
        '{5'h09, 32'h000001C5, 1'b0, 1'b1, 16'h0000},
        '{5'h19, 32'h01850000, 1'b1, 1'b0, 16'hFFFF},
        '{5'h09, 32'h00000100, 1'b0, 1'b0, 16'h0000},
        '{5'h19, 32'h01451234, 1'b0, 1'b0, 16'h0000},
        '{5'h19, 32'h01850000, 1'b1, 1'b0, 16'hFFFF},
        '{5'h09, 32'h00000130, 1'b0, 1'b0, 16'h0000},
        '{5'h19, 32'h01100F0F, 1'b0, 1'b1, 16'h0000},
        '{5'h19, 32'h01BF0000, 1'b1, 1'b0, 16'h0F0F},
        '{5'h19, 32'h017FF0F0, 1'b0, 1'b1, 16'h0000},
        '{5'h19, 32'h01BF0000, 1'b1, 1'b0, 16'hF0F0}};
    ////////////////////////////////////////////////////////////////////
    eeprom_command_port #(.WRITE_CYCLES(200), .ERASE_CYCLES(100),
        .ALL_CYCLES(1500), .FIFO_DEPTH(8)) i_eeprom_command_port (
        .clock(clock), .rstn(rstn), .chip_select(chip_select),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_out_en(serial_data_out_en));
    link_master i_link_master (.clock(clock), .line(line),
        .chip_select(chip_select), .serial_clock(serial_clock),
        .serial_data_in(serial_data_in));
    ////////////////////////////////////////////////////////////////////
    // one frame, then a status poll until ready
    task automatic run_row(input row_t r);
        logic [15:0] rd;
        logic busy, ready;
        i_link_master.xfer(int'(r.n), r.v, rd);
        if (r.c) `CHK("read word", r.e, rd)
        i_link_master.poll(busy, ready);
        `CHK("busy", r.b, busy)
        `CHK("ready", 1'b1, ready)
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // free running 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end
    // hang guard, well above the table's run time
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            finish_test();
        end
    end
    // table first, then a reset in mid-run
    initial begin
        repeat (10) @(negedge clock);
        `CHK("reset release", 1'b0, serial_data_out_en)
        rstn <= 1'b1;
        repeat (3) @(negedge clock);
        foreach (rows[i]) run_row(rows[i]);
        rstn <= 1'b0;
        repeat (2) @(negedge clock);
        rstn <= 1'b1;
        repeat (3) @(negedge clock);
        `CHK("reset out", 1'b0, serial_data_out_en)
        run_row(row_t'{5'h19, 32'h017F1234, 1'b0, 1'b0, 16'h0000});
        run_row(rows[17]);
        finish_test();
    end
endmodule
`default_nettype wire
